// ### src/tabm_defs.vh
// tabm_defs.vh: constants for the channel-0 transmit bit-1 input mux.
// assumes inclusion by bare name from the design file; definitions only.
// Functional notes
// - the pin role comes from configuration: add bus enabled wins, else the mode picks HDLC or ATM.
// - with the add bus enabled the pin is bit 1 of the eight-bit channel-0 add data bus.
// - in add-bus use the pin is latched on every falling edge of the add-bus clock.
// - with add bus off and HDLC mode, the pin is bit 1 of the eight-bit HDLC transmit bus.
// - in HDLC mode the block drives a byte-rate transmit clock out to the system side.
// - in HDLC mode the whole transmit byte is sampled on the rising edge of that byte clock.
// - the pin is GFC data only in ATM UNI mode and that role is ignored otherwise.
`ifndef TABM_DEFS_VH
`define TABM_DEFS_VH
`define TABM_MODE_W 2
`define TABM_MODE_HDLC 2'h1
`define TABM_MODE_ATM 2'h2
`define TABM_ROLE_NONE 2'h0
`define TABM_ROLE_ADD 2'h1
`define TABM_ROLE_HDLC 2'h2
`define TABM_ROLE_ATM 2'h3
`define TABM_BIT 1
`define TABM_CLK_NS 25
`define TABM_BYTE_CLK_NS 200
// byte clock half period in clk cycles: 200 ns / 25 ns / 2, sized to fit the divider
`define TABM_HALF_CYC 4'h4
`define TABM_DIV_W 4
`endif

// ### src/tabm_mux.v
// tabm_mux.v: role mux and capture for bit 1 of the channel-0 transmit byte bus.
// assumes pins are asynchronous to clk; configuration inputs are quasi-static on clk.
`timescale 1ns/100ps
`include "tabm_defs.vh"
module tabm_mux (
   input wire clk,
   input wire rst_b,
   input wire add_bus_enable,
   input wire [`TABM_MODE_W-1:0] op_mode,
   input wire add_bus_ch0_clock,
   input wire [7:0] add_bus_ch0_data,
   input wire [7:0] hdlc_tx_ch0_byte_bus,
   output reg [1:0] role_ff,
   output reg [7:0] add_byte_ff,
   output reg add_byte_valid_ff,
   output reg hdlc_tx_ch0_byte_clock,
   output reg [7:0] hdlc_byte_ff,
   output reg hdlc_byte_valid_ff,
   output reg atm_tx_ch0_flow_ctl_in,
   output reg atm_gfc_valid_ff
);
   // the add data and the HDLC bus share pins but are synchronised apart,
   // so a role change never mixes stages of the two paths
   wire [7:0] add_sync;
   wire [7:0] hdlc_sync;
   // three stages on the add clock: two to synchronise, one to find the edge
   reg [2:0] clk_sync_ff;
   reg [1:0] nxt_role;
   reg nxt_add_valid;
   reg [7:0] nxt_add_byte;
   reg [`TABM_DIV_W-1:0] div_ff;
   reg [`TABM_DIV_W-1:0] nxt_div;
   reg nxt_byte_clock;
   reg nxt_hdlc_valid;
   reg [7:0] nxt_hdlc_byte;
   reg nxt_gfc;
   reg nxt_gfc_valid;
   wire [`TABM_DIV_W-1:0] half_cyc;
   wire add_fall;
   wire div_wrap;
   wire byte_rise;
   genvar gi;

   assign half_cyc = `TABM_HALF_CYC;
   // the third stage only compares; nothing but the second stage reads the first
   assign add_fall = clk_sync_ff[2] & ~clk_sync_ff[1];
   // byte clock toggles when the divider wraps; a wrap with the clock low is a rising edge
   assign div_wrap = (div_ff == half_cyc - 4'h1);
   assign byte_rise = div_wrap & ~hdlc_tx_ch0_byte_clock;

   // two flops per data pin; the data path is one stage shorter than the clock path,
   // so the byte seen at the detected edge was on the pins as the add clock fell
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin_sync
         reg add_s1_ff;
         reg add_s2_ff;
         reg hdlc_s1_ff;
         reg hdlc_s2_ff;
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               add_s1_ff <= 1'b0;
               add_s2_ff <= 1'b0;
               hdlc_s1_ff <= 1'b0;
               hdlc_s2_ff <= 1'b0;
            end else begin
               add_s1_ff <= add_bus_ch0_data[gi];
               add_s2_ff <= add_s1_ff;
               hdlc_s1_ff <= hdlc_tx_ch0_byte_bus[gi];
               hdlc_s2_ff <= hdlc_s1_ff;
            end
         end
         assign add_sync[gi] = add_s2_ff;
         assign hdlc_sync[gi] = hdlc_s2_ff;
      end
   endgenerate

   // reset value low: an idle-high add clock then shows a rise, never a false fall
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_sync_ff <= 3'h0;
      end else begin
         clk_sync_ff <= {clk_sync_ff[1:0], add_bus_ch0_clock};
      end
   end

   // add bus enabled wins over any operating mode
   always @* begin
      nxt_role = `TABM_ROLE_NONE;
      if (add_bus_enable) begin
         nxt_role = `TABM_ROLE_ADD;
      end else if (op_mode == `TABM_MODE_HDLC) begin
         nxt_role = `TABM_ROLE_HDLC;
      end else if (op_mode == `TABM_MODE_ATM) begin
         nxt_role = `TABM_ROLE_ATM;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         role_ff <= `TABM_ROLE_NONE;
      end else begin
         role_ff <= nxt_role;
      end
   end

   // add-bus capture: one byte per falling edge of the add clock
   always @* begin
      nxt_add_byte = add_byte_ff;
      nxt_add_valid = 1'b0;
      if (nxt_role == `TABM_ROLE_ADD && add_fall) begin
         nxt_add_byte = add_sync;
         nxt_add_valid = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         add_byte_ff <= 8'h00;
         add_byte_valid_ff <= 1'b0;
      end else begin
         add_byte_ff <= nxt_add_byte;
         add_byte_valid_ff <= nxt_add_valid;
      end
   end

   // byte clock divider; clock parked low and divider cleared outside HDLC mode,
   // so the first byte after a mode change always gets a full low half
   always @* begin
      nxt_div = 4'h0;
      nxt_byte_clock = 1'b0;
      if (nxt_role == `TABM_ROLE_HDLC) begin
         nxt_byte_clock = hdlc_tx_ch0_byte_clock;
         if (div_wrap) begin
            nxt_div = 4'h0;
            nxt_byte_clock = ~hdlc_tx_ch0_byte_clock;
         end else begin
            nxt_div = div_ff + 4'h1;
         end
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_ff <= 4'h0;
         hdlc_tx_ch0_byte_clock <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         hdlc_tx_ch0_byte_clock <= nxt_byte_clock;
      end
   end

   // whole byte taken on the same clk edge that drives the byte clock high;
   // the system side must have settled it at least two clk cycles earlier
   always @* begin
      nxt_hdlc_byte = hdlc_byte_ff;
      nxt_hdlc_valid = 1'b0;
      if (nxt_role == `TABM_ROLE_HDLC && byte_rise) begin
         nxt_hdlc_byte = hdlc_sync;
         nxt_hdlc_valid = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hdlc_byte_ff <= 8'h00;
         hdlc_byte_valid_ff <= 1'b0;
      end else begin
         hdlc_byte_ff <= nxt_hdlc_byte;
         hdlc_byte_valid_ff <= nxt_hdlc_valid;
      end
   end

   // flow-control bit follows the synchronised pin every cycle; cell timing is
   // left to the consumer, which is why the valid flag is a level here
   always @* begin
      nxt_gfc = 1'b0;
      nxt_gfc_valid = 1'b0;
      if (nxt_role == `TABM_ROLE_ATM) begin
         nxt_gfc = add_sync[`TABM_BIT];
         nxt_gfc_valid = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         atm_tx_ch0_flow_ctl_in <= 1'b0;
         atm_gfc_valid_ff <= 1'b0;
      end else begin
         atm_tx_ch0_flow_ctl_in <= nxt_gfc;
         atm_gfc_valid_ff <= nxt_gfc_valid;
      end
   end

   // limitation: configuration is taken without synchronisers, so it must only
   // change while rst_b is low or while the pins are idle
endmodule

// ### verification/tabm_mux_properties.sv
// tabm_mux_properties.sv: port checks on tabm_mux.
// assumes configuration only changes while rst_b is low.
`timescale 1ns/100ps
module tabm_mux_properties (input wire clk, rst_b, add_bus_enable, add_bus_ch0_clock,
   add_byte_valid_ff, hdlc_tx_ch0_byte_clock, hdlc_byte_valid_ff, atm_tx_ch0_flow_ctl_in,
   atm_gfc_valid_ff, input wire [1:0] op_mode, role_ff,
   input wire [7:0] hdlc_tx_ch0_byte_bus, hdlc_byte_ff);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_hi; hdlc_tx_ch0_byte_clock[*4]; endsequence
   sequence s_lo; !hdlc_tx_ch0_byte_clock[*4]; endsequence
   a_role_pick: assert property ($past(rst_b) |-> role_ff == (add_bus_enable ? 2'h1 :
      (op_mode == 2'h1) ? 2'h2 : (op_mode == 2'h2) ? 2'h3 : 2'h0)) else $error("role");
   a_add_role: assert property (add_byte_valid_ff |-> role_ff == 2'h1) else $error("add");
   a_add_fall: assert property (role_ff == 2'h1 && $fell(add_bus_ch0_clock) |-> ##[1:7]
      add_byte_valid_ff) else $error("fall");
   a_hdlc_role: assert property (hdlc_byte_valid_ff |-> role_ff == 2'h2) else $error("hd");
   a_bclk_park: assert property (role_ff != 2'h2 |-> !hdlc_tx_ch0_byte_clock)
      else $error("park");
   a_bclk_rate: assert property ($rose(hdlc_tx_ch0_byte_clock) |-> s_hi ##1 s_lo ##1
      hdlc_tx_ch0_byte_clock) else $error("rate");
   a_byte_take: assert property (hdlc_byte_valid_ff |-> $rose(hdlc_tx_ch0_byte_clock) &&
      hdlc_byte_ff == $past(hdlc_tx_ch0_byte_bus, 3)) else $error("take");
   a_gfc_gate: assert property (role_ff != 2'h3 |-> !atm_tx_ch0_flow_ctl_in &&
      !atm_gfc_valid_ff) else $error("gfc");
endmodule
bind tabm_mux tabm_mux_properties u_tabm_mux_properties (.clk, .rst_b, .add_bus_enable,
   .add_bus_ch0_clock, .add_byte_valid_ff, .hdlc_tx_ch0_byte_clock, .hdlc_byte_valid_ff,
   .atm_tx_ch0_flow_ctl_in, .atm_gfc_valid_ff, .op_mode, .role_ff, .hdlc_tx_ch0_byte_bus,
   .hdlc_byte_ff);

// ### verification/tabm_src.sv
// tabm_src.sv: system-side source for the shared channel-0 transmit pins.
// assumes run is held only while the add bus is in use.
`timescale 1ns/100ps
module tabm_src (input wire run, bclk, output reg aclk = 1'h1, output reg [7:0] d = 8'h5a);
   // odd start offset keeps the add clock out of phase with clk; still outside frames
   initial #7 forever #100 if (run) aclk = ~aclk;
   always @(posedge aclk) d <= d + 8'h25; // moves half a period before the falling edge
   always @(negedge bclk) d <= d + 8'h13; // settles well ahead of the rising edge
endmodule

// ### verification/tabm_mux_tb.sv
// tabm_mux_tb.sv: self-checking bench for tabm_mux fed by tabm_src.
// assumes the checker is bound onto tabm_mux.
`timescale 1ns/100ps
module tabm_mux_tb;
   reg clk = 1'h0, rst_b = 1'h0, en = 1'h0, run = 1'h0;
   reg [1:0] md = 2'h0;
   reg [8:0] got;
   integer err_count = 0, n_tests = 0, i;
   wire ac, bc, av, hv, atm, gv;
   wire [1:0] role;
   wire [7:0] d, ab, hb;
   initial forever #12.5 clk = ~clk;
   tabm_src u_tabm_src (.run(run), .bclk(bc), .aclk(ac), .d(d));
   tabm_mux u_tabm_mux (.clk(clk), .rst_b(rst_b), .add_bus_enable(en), .op_mode(md),
      .add_bus_ch0_clock(ac), .add_bus_ch0_data(d), .hdlc_tx_ch0_byte_bus(d), .role_ff(role),
      .add_byte_ff(ab), .add_byte_valid_ff(av), .hdlc_tx_ch0_byte_clock(bc),
      .hdlc_byte_ff(hb), .hdlc_byte_valid_ff(hv), .atm_tx_ch0_flow_ctl_in(atm),
      .atm_gfc_valid_ff(gv));
   task chk(input [8:0] g, w);
      begin
         n_tests = n_tests + 1;
         if (g !== w) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0t %h %h", $time, g, w);
         end
      end
   endtask
   task finish_test;
      begin
         $display("errors %0d checks %0d", err_count, n_tests);
         if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task cfg(input e, input [1:0] m, r);
      begin
         rst_b = 1'h0;
         en = e;
         md = m;
         run = e;
         repeat (16) @(negedge clk);
         rst_b = 1'h1;
         repeat (12) @(negedge clk);
         chk({7'h0, role}, {7'h0, r});
      end
   endtask
   task t_add;
      // hdlc mode also set, so the add bus has to win
      for (i = 0; i < 4; i = i + 1) begin
         @(negedge ac) got = {1'h1, d};
         @(posedge av) @(negedge clk) chk({av, ab}, got);
      end
   endtask
   task t_hdlc;
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge bc) got = {1'h1, d};
         @(negedge clk) chk({hv, hb}, got);
      end
   endtask
   task t_atm;
      chk({7'h0, gv, atm}, {7'h0, 1'h1, d[1]});
   endtask
   initial begin
      cfg(1'h1, 2'h1, 2'h1);
      t_add;
      cfg(1'h0, 2'h1, 2'h2);
      t_hdlc;
      cfg(1'h0, 2'h2, 2'h3);
      t_atm;
      cfg(1'h0, 2'h3, 2'h0);
      finish_test;
   end
   initial begin
      #20000;
      err_count = err_count + 1;
      finish_test;
   end
endmodule
